// ### rtl/prs_range_search.sv
// Preselector range search with APB registers
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/100ps
`include "prs_defs.svh"
module prs_range_search #(
   parameter int ADDR_W = 8,
   parameter int STEP_DIV = `PRS_STEP_CYC,
   parameter int OVL_CYC = `PRS_OVL_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [`PRS_TUNE_W-1:0] tune_word,
   input wire logic ovl_pulse,
   output logic [15:0] range_sel,
   output logic [15:0] relay_drive,
   output logic low_bank_on,
   output logic high_bank_on,
   output logic tracking_sel,
   output logic ovl_stretched,
   output logic search_busy,
   output logic irq
);
   localparam int DIV_W = $clog2(STEP_DIV);

   // ============================================================
   // Functions

   // Lower cutoff, 4 decades: tens(2b) MHz 100k 10k
   function automatic logic [13:0] prs_lower(input logic [3:0] r);
      logic [13:0] v;
      v = 14'h0000;
      unique case (r)
         4'h0: v = 14'h0001;
         4'h1: v = 14'h0015;
         4'h2: v = 14'h0020;
         4'h3: v = 14'h0028;
         4'h4: v = 14'h0039;
         4'h5: v = 14'h0054;
         4'h6: v = 14'h0075;
         4'h7: v = 14'h0105;
         4'h8: v = 14'h0145;
         4'h9: v = 14'h0200;
         4'ha: v = 14'h0270;
         4'hb: v = 14'h0370;
         4'hc: v = 14'h0520;
         4'hd: v = 14'h0720;
         4'he: v = 14'h1000;
         4'hf: v = 14'h2000;
      endcase
      return v; // R2
   endfunction : prs_lower

   // Upper cutoff cut to 4 decades; the dropped digits are all nines
   function automatic logic [13:0] prs_upper(input logic [3:0] r);
      logic [13:0] v;
      v = 14'h0000;
      unique case (r)
         4'h0: v = 14'h0014;
         4'h1: v = 14'h0019;
         4'h2: v = 14'h0027;
         4'h3: v = 14'h0038;
         4'h4: v = 14'h0053;
         4'h5: v = 14'h0074;
         4'h6: v = 14'h0104;
         4'h7: v = 14'h0144;
         4'h8: v = 14'h0199;
         4'h9: v = 14'h0269;
         4'ha: v = 14'h0369;
         4'hb: v = 14'h0519;
         4'hc: v = 14'h0719;
         4'hd: v = 14'h0999;
         4'he: v = 14'h1999;
         4'hf: v = 14'h2999;
      endcase
      return v; // R2
   endfunction : prs_upper

   // One-of-sixteen decode of the range counter
   function automatic logic [15:0] prs_decode(input logic [3:0] r);
      return 16'h0001 << r; // R9
   endfunction : prs_decode

   // Mapped register check
   function automatic logic prs_hit(input logic [ADDR_W-1:0] a);
      return (a == ADDR_W'(`PRS_OFF_CTRL)) || (a == ADDR_W'(`PRS_OFF_STATUS)) ||
         (a == ADDR_W'(`PRS_OFF_TUNE)) || (a == ADDR_W'(`PRS_OFF_INT_STAT)) ||
         (a == ADDR_W'(`PRS_OFF_INT_MASK));
   endfunction : prs_hit

   // ============================================================
   // Declarations
   prs_pkg::prs_state_t state;
   prs_pkg::prs_state_t next_state;
   logic [DIV_W-1:0] div_cnt;
   logic step_tick;
   logic [3:0] range_idx;
   logic dir_up;
   logic first_done;
   logic [13:0] tune_q;
   logic tune_chg;
   logic too_low;
   logic too_high;
   logic step_up;
   logic step_dn;
   logic found;
   logic hunting;
   logic relays_on;
   logic relay_en;
   logic restart_req;
   logic restart;
   logic lock_evt;
   logic [`PRS_INT_W-1:0] int_stat;
   logic [`PRS_INT_W-1:0] int_mask;
   logic [`PRS_INT_W-1:0] int_set;
   logic [`PRS_INT_W-1:0] int_clr;
   logic [`PRS_INT_W-1:0] next_int_stat;
   logic apb_setup;
   logic apb_wr;
   logic [31:0] rd_mux;

   // ============================================================
   // Search clock

   // Free-running divider; 500 Hz is slow enough for relays to settle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= '0;
         step_tick <= 1'b0;
      end else if (div_cnt == DIV_W'(STEP_DIV - 1)) begin
         div_cnt <= '0;
         step_tick <= 1'b1; // R8
      end else begin
         div_cnt <= div_cnt + DIV_W'(1);
         step_tick <= 1'b0;
      end
   end

   // ============================================================
   // Comparators and direction logic

   // Tuning word is compared as packed BCD; digit order keeps it monotonic
   always_comb begin
      too_low = tune_word > prs_upper(range_idx); // R5
      too_high = tune_word < prs_lower(range_idx); // R6
      step_up = too_low && (range_idx != 4'hf); // R10
      step_dn = too_high && !too_low && (range_idx != 4'h0); // R10
      found = !step_up && !step_dn; // R7
      hunting = (state != prs_pkg::PRS_LOCK);
      tune_chg = (tune_word != tune_q); // R15
      restart = tune_chg || restart_req;
      lock_evt = hunting && step_tick && found;
   end

   // Previous tuning word, to spot a new setting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tune_q <= 14'h0000;
      end else begin
         tune_q <= tune_word; // R3
      end
   end

   // ============================================================
   // Sequencer

   // Out-of-band words lock at range 1 or 16 rather than hunting forever
   always_comb begin
      next_state = state;
      unique case (state)
         prs_pkg::PRS_BOOT: begin
            if (step_tick && found) begin
               next_state = prs_pkg::PRS_LOCK; // R10
            end
         end
         prs_pkg::PRS_SEARCH: begin
            if (step_tick && found) begin
               next_state = prs_pkg::PRS_LOCK; // R10
            end
         end
         prs_pkg::PRS_LOCK: begin
            if (restart) begin
               next_state = prs_pkg::PRS_SEARCH; // R15
            end
         end
         default: begin
            next_state = prs_pkg::PRS_BOOT;
         end
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= prs_pkg::PRS_BOOT;
      end else begin
         state <= next_state;
      end
   end

   // Range counter moves one step per tick while hunting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         range_idx <= `PRS_RST_RANGE;
         dir_up <= 1'b1;
      end else if (hunting && step_tick) begin
         dir_up <= too_low; // R10
         if (step_up) begin
            range_idx <= range_idx + 4'h1; // R5 R8
         end else if (step_dn) begin
            range_idx <= range_idx - 4'h1; // R6 R8
         end
      end
   end

   // First search after power-on finished
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_done <= 1'b0;
      end else if (state == prs_pkg::PRS_BOOT && lock_evt) begin
         first_done <= 1'b1; // R12
      end
   end

   // ============================================================
   // Relay and bank drive

   // Use next_state so relays drop on the same edge a search starts
   assign relays_on = (next_state == prs_pkg::PRS_LOCK) && relay_en; // R11 R12

   // Registered relay outputs; relay_drive and banks stay off while the counter walks, range_sel follows it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         range_sel <= 16'h0001;
         relay_drive <= 16'h0000;
         low_bank_on <= 1'b0;
         high_bank_on <= 1'b0;
         tracking_sel <= 1'b0;
         search_busy <= 1'b1;
      end else begin
         range_sel <= prs_decode(range_idx); // R9
         relay_drive <= relays_on ? prs_decode(range_idx) : 16'h0000; // R9 R11
         low_bank_on <= relays_on && !range_idx[3]; // R13
         high_bank_on <= relays_on && range_idx[3]; // R13
         tracking_sel <= (range_idx[3:1] == 3'b111); // R1
         search_busy <= (next_state != prs_pkg::PRS_LOCK);
      end
   end

   // Overload stretcher
   prs_pulse_stretch #(
      .HOLD(OVL_CYC)
   ) u_ovl (
      .pclk(pclk),
      .presetn(presetn),
      .pulse_in(ovl_pulse),
      .stretched(ovl_stretched)
   );

   // ============================================================
   // APB slave

   // No wait states: answer is prepared during the setup cycle
   assign apb_setup = psel && !penable;
   assign apb_wr = psel && penable && pready && pwrite && !pslverr;

   // Read data mux
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (paddr == ADDR_W'(`PRS_OFF_CTRL)) begin
         rd_mux[`PRS_CTRL_RELAY_EN] = relay_en;
      end else if (paddr == ADDR_W'(`PRS_OFF_STATUS)) begin
         rd_mux[`PRS_ST_RANGE_LSB +: 4] = range_idx;
         rd_mux[`PRS_ST_SEARCH] = hunting;
         rd_mux[`PRS_ST_LOCK] = !hunting;
         rd_mux[`PRS_ST_UP] = dir_up;
         rd_mux[`PRS_ST_HIGH] = range_idx[3];
         rd_mux[`PRS_ST_READY] = first_done;
      end else if (paddr == ADDR_W'(`PRS_OFF_TUNE)) begin
         rd_mux[`PRS_TUNE_W-1:0] = tune_word; // R4
      end else if (paddr == ADDR_W'(`PRS_OFF_INT_STAT)) begin
         rd_mux[`PRS_INT_W-1:0] = int_stat;
      end else if (paddr == ADDR_W'(`PRS_OFF_INT_MASK)) begin
         rd_mux[`PRS_INT_W-1:0] = int_mask;
      end
   end

   // Handshake and read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= apb_setup;
         pslverr <= apb_setup && !prs_hit(paddr);
         prdata <= (apb_setup && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // Control register; restart is a self-clearing pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         relay_en <= `PRS_RST_RELAY_EN;
         restart_req <= 1'b0;
      end else begin
         restart_req <= apb_wr && (paddr == ADDR_W'(`PRS_OFF_CTRL)) && pwdata[`PRS_CTRL_RESTART];
         if (apb_wr && (paddr == ADDR_W'(`PRS_OFF_CTRL))) begin
            relay_en <= pwdata[`PRS_CTRL_RELAY_EN];
         end
      end
   end

   // ============================================================
   // Interrupts

   // Set beats a same-cycle write-one-to-clear
   always_comb begin
      int_set = '0;
      int_set[`PRS_INT_LOCK] = lock_evt;
      int_set[`PRS_INT_OVL] = ovl_pulse;
      int_set[`PRS_INT_TUNE] = tune_chg;
      int_clr = (apb_wr && (paddr == ADDR_W'(`PRS_OFF_INT_STAT))) ? pwdata[`PRS_INT_W-1:0] : '0;
      next_int_stat = (int_stat & ~int_clr) | int_set;
   end

   // Status, mask and level interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat <= '0;
         int_mask <= `PRS_RST_MASK;
         irq <= 1'b0;
      end else begin
         int_stat <= next_int_stat;
         if (apb_wr && (paddr == ADDR_W'(`PRS_OFF_INT_MASK))) begin
            int_mask <= pwdata[`PRS_INT_W-1:0];
         end
         irq <= |(next_int_stat & int_mask);
      end
   end

   // ============================================================
   // Checks
   property p_relay_off;
      @(posedge pclk) disable iff (!presetn)
      (state != prs_pkg::PRS_LOCK) |-> (relay_drive == 16'h0000);
   endproperty
   a_relay_off: assert property (p_relay_off) else $error("relay on during search"); // R11

   property p_boot_hold;
      @(posedge pclk) disable iff (!presetn)
      !first_done |-> !low_bank_on && !high_bank_on && (relay_drive == 16'h0000);
   endproperty
   a_boot_hold: assert property (p_boot_hold) else $error("bank on before first lock"); // R12

   property p_step_up;
      @(posedge pclk) disable iff (!presetn)
      hunting && step_tick && too_low && range_idx != 4'hf |=> range_idx == $past(range_idx) + 4'h1;
   endproperty
   a_step_up: assert property (p_step_up) else $error("range did not step up"); // R5

   property p_step_dn;
      @(posedge pclk) disable iff (!presetn)
      hunting && step_tick && too_high && range_idx != 4'h0 |=> range_idx == $past(range_idx) - 4'h1;
   endproperty
   a_step_dn: assert property (p_step_dn) else $error("range did not step down"); // R6

   property p_no_tick_hold;
      @(posedge pclk) disable iff (!presetn)
      !step_tick |=> $stable(range_idx);
   endproperty
   a_no_tick_hold: assert property (p_no_tick_hold) else $error("range moved without tick"); // R8

   property p_lock_keep;
      @(posedge pclk) disable iff (!presetn)
      state == prs_pkg::PRS_LOCK && !restart |=> state == prs_pkg::PRS_LOCK && $stable(range_idx);
   endproperty
   a_lock_keep: assert property (p_lock_keep) else $error("locked range changed"); // R7 R10

   property p_onehot;
      @(posedge pclk) disable iff (!presetn)
      $onehot(range_sel) && (relay_drive == 16'h0000 || relay_drive == range_sel);
   endproperty
   a_onehot: assert property (p_onehot) else $error("decoder not one-hot"); // R9

   property p_bank;
      @(posedge pclk) disable iff (!presetn)
      high_bank_on |-> !low_bank_on && relay_drive[7:0] == 8'h00 && relay_drive[15:8] != 8'h00;
   endproperty
   a_bank: assert property (p_bank) else $error("bank select mismatch"); // R13

   property p_restart;
      @(posedge pclk) disable iff (!presetn)
      state == prs_pkg::PRS_LOCK && tune_chg |=> state == prs_pkg::PRS_SEARCH && search_busy;
   endproperty
   a_restart: assert property (p_restart) else $error("tuning change missed"); // R15
endmodule : prs_range_search

// ### rtl/prs_defs.svh
// Constants for the preselector range search block
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH
// ============================================================
// Functional notes
// (R1) Sixteen ranges; ranges 15 and 16 track
// (R2) Fixed lower and upper cutoff per range
// (R3) Tuning source gives a 14-bit word
// (R4) Word: 2-bit tens, then three BCD digits
// (R5) Above upper cutoff: step range up
// (R6) Below lower cutoff: step range down
// (R7) Inside both cutoffs: keep range selected
// (R8) One range step per 500 Hz tick
// (R9) One-of-sixteen decode drives stores and relays
// (R10) Direction from compares; inhibit once found
// (R11) Relays off while search runs
// (R12) No relay sequencing during first search
// (R13) Range above 8: high bank, low off
// (R14) Stretch overload pulse toward control logic
// (R15) Tuning change restarts search from current
// ============================================================
// Timing
`define PRS_CLK_HZ 20000000
`define PRS_CLK_PERIOD_NS 50
`define PRS_STEP_HZ 500
`define PRS_STEP_CYC (`PRS_CLK_HZ / `PRS_STEP_HZ)
`define PRS_OVL_STRETCH_NS 20000
`define PRS_OVL_CYC ((`PRS_OVL_STRETCH_NS + `PRS_CLK_PERIOD_NS - 1) / `PRS_CLK_PERIOD_NS)
// ============================================================
// Register offsets
`define PRS_OFF_CTRL 8'h00
`define PRS_OFF_STATUS 8'h04
`define PRS_OFF_TUNE 8'h08
`define PRS_OFF_INT_STAT 8'h0c
`define PRS_OFF_INT_MASK 8'h10
// ============================================================
// Field positions
`define PRS_CTRL_RELAY_EN 0
`define PRS_CTRL_RESTART 1
`define PRS_ST_RANGE_LSB 0
`define PRS_ST_SEARCH 4
`define PRS_ST_LOCK 5
`define PRS_ST_UP 6
`define PRS_ST_HIGH 7
`define PRS_ST_READY 8
`define PRS_INT_LOCK 0
`define PRS_INT_OVL 1
`define PRS_INT_TUNE 2
`define PRS_INT_W 3
`define PRS_TUNE_W 14
// ============================================================
// Reset values
`define PRS_RST_RELAY_EN 1'b1
`define PRS_RST_MASK 3'h0
`define PRS_RST_RANGE 4'h0
`endif

// ### rtl/prs_pkg.sv
// Types shared by the preselector range search block
package prs_pkg;
   // Search sequencer states, one-hot
   typedef enum logic [2:0] {
      PRS_BOOT = 3'b001,
      PRS_SEARCH = 3'b010,
      PRS_LOCK = 3'b100
   } prs_state_t;
endpackage : prs_pkg

// ### rtl/prs_pulse_stretch.sv
// Overload pulse stretcher
`timescale 1ns/100ps
`include "prs_defs.svh"
module prs_pulse_stretch #(
   parameter int HOLD = `PRS_OVL_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pulse_in,
   output logic stretched
);
   localparam int CW = $clog2(HOLD + 1);
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;

   // Retrigger on every pulse so a burst reads as one long overload
   always_comb begin
      if (pulse_in) begin
         next_cnt = CW'(HOLD);
      end else if (cnt != '0) begin
         next_cnt = cnt - CW'(1);
      end else begin
         next_cnt = '0;
      end
   end

   // Counter and registered output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
         stretched <= 1'b0;
      end else begin
         cnt <= next_cnt; // R14
         stretched <= (next_cnt != '0); // R14
      end
   end

   // ============================================================
   // Checks
   property p_ovl_catch;
      @(posedge pclk) disable iff (!presetn)
      pulse_in |=> stretched;
   endproperty
   a_ovl_catch: assert property (p_ovl_catch) else $error("overload pulse not stretched"); // R14

   property p_ovl_hold;
      @(posedge pclk) disable iff (!presetn)
      $fell(stretched) |-> ($past(cnt) == CW'(1)) && !$past(pulse_in);
   endproperty
   a_ovl_hold: assert property (p_ovl_hold) else $error("stretched pulse ended early"); // R14
endmodule : prs_pulse_stretch

// ### tb/prs_tune_src.sv
// Front-panel tuning source model driving the range search tuning word
`timescale 1ns/100ps
module prs_tune_src (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] freq_10k,
   output logic [13:0] tune_word
);
   // ============================================================
   // Tuning word
   // Registered so the block never sees a half-changed word between digits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tune_word <= 14'h0000;
      end else begin
         tune_word <= {2'(freq_10k / 1000), 4'((freq_10k / 100) % 10), 4'((freq_10k / 10) % 10), 4'(freq_10k % 10)};
      end
   end
endmodule : prs_tune_src

// ### tb/tb_top.sv
// Self-checking bench for the preselector range search
`timescale 1ns/100ps
`include "prs_defs.svh"
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, ovl_pulse, pready, pslverr, err;
   logic low_bank_on, high_bank_on, tracking_sel, ovl_stretched, search_busy, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [13:0] tune_word;
   logic [15:0] range_sel, relay_drive;
   logic [11:0] freq_10k;
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;
   int n;
   // Tuning value in 10 kHz units, expected range index, expected tuning word
   localparam int ROWS[9][3] = '{'{200, 9, 14'h0200}, '{0, 0, 14'h0000}, '{3999, 15, 14'h3999}, '{145, 8, 14'h0145},
      '{144, 7, 14'h0144}, '{1000, 14, 14'h1000}, '{999, 13, 14'h0999}, '{15, 1, 14'h0015}, '{14, 0, 14'h0014}};

   // ============================================================
   // Design, tuning source and clock
   // Short step and stretch counts keep the run brief
   prs_range_search #(.ADDR_W(8), .STEP_DIV(8), .OVL_CYC(4)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tune_word(tune_word),
      .ovl_pulse(ovl_pulse), .range_sel(range_sel), .relay_drive(relay_drive), .low_bank_on(low_bank_on),
      .high_bank_on(high_bank_on), .tracking_sel(tracking_sel), .ovl_stretched(ovl_stretched),
      .search_busy(search_busy), .irq(irq));
   prs_tune_src i_src (.pclk(pclk), .presetn(presetn), .freq_10k(freq_10k), .tune_word(tune_word));

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // Hang guard, well above the longest expected run
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         end_sim();
      end
   end

   // ============================================================
   // Tasks
   task automatic end_sim();
      if (fail_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One APB transfer; request held until the rising edge that samples pready high, data taken there
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic chk_reg(input string name, input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0);
      chk(name, exp, rd & mask);
      chk("pslverr", 32'h0, {31'h0, err});
   endtask : chk_reg

   task automatic wait_idle();
      while (search_busy !== 1'b0) begin
         @(negedge pclk);
         n++;
      end
   endtask : wait_idle

   task automatic tune(input int f);
      @(posedge pclk);
      freq_10k <= 12'(f);
      repeat (3) @(negedge pclk);
      n = 3;
   endtask : tune

   task automatic chk_outs(input int idx);
      chk("range_sel", 32'(16'h0001 << idx), 32'(range_sel));
      chk("relay_drive", 32'(16'h0001 << idx), 32'(relay_drive));
      chk("high_bank_on", 32'(idx >= 8), 32'(high_bank_on));
      chk("low_bank_on", 32'(idx < 8), 32'(low_bank_on));
      chk("tracking_sel", 32'(idx >= 14), 32'(tracking_sel));
      chk_reg("status", `PRS_OFF_STATUS, 32'h3f, 32'h20 | idx);
   endtask : chk_outs

   // ============================================================
   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ovl_pulse = 1'b0;
      freq_10k = 12'h000;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk("busy_boot", 32'h1, 32'(search_busy));
      chk("relay_boot", 32'h0, 32'(relay_drive));
      wait_idle();
      chk_outs(0);
      chk_reg("ctrl_rst", `PRS_OFF_CTRL, 32'hffffffff, 32'h1);
      chk_reg("mask_rst", `PRS_OFF_INT_MASK, 32'hffffffff, 32'h0);
      // Table of tunings: walks up, down, past the top and across bank and cutoff edges
      for (int i = 0; i < 9; i++) begin
         tune(ROWS[i][0]);
         chk("busy_search", 32'h1, 32'(search_busy));
         chk("relay_search", 32'h0, 32'(relay_drive));
         wait_idle();
         if (i == 0) chk("step_time", 32'h1, 32'(n >= 70 && n <= 90));
         chk_outs(ROWS[i][1]);
         chk_reg("tune", `PRS_OFF_TUNE, 32'h3fff, ROWS[i][2]);
      end
      // Relays refused while disabled, range kept
      apb(1'b1, `PRS_OFF_CTRL, 32'h0);
      repeat (2) @(negedge pclk);
      chk("relay_off", 32'h0, 32'(relay_drive));
      chk("bank_off", 32'h0, 32'({high_bank_on, low_bank_on}));
      chk("range_kept", 32'h1, 32'(range_sel));
      // Restart with relays back on finds the same range
      apb(1'b1, `PRS_OFF_CTRL, 32'h3);
      repeat (3) @(negedge pclk);
      wait_idle();
      chk_outs(0);
      // Interrupt raise, mask and write-one clear
      chk_reg("int_stat", `PRS_OFF_INT_STAT, 32'h7, 32'h5);
      chk("irq_masked", 32'h0, 32'(irq));
      apb(1'b1, `PRS_OFF_INT_MASK, 32'h1);
      repeat (2) @(negedge pclk);
      chk("irq_on", 32'h1, 32'(irq));
      apb(1'b1, `PRS_OFF_INT_STAT, 32'h5);
      repeat (2) @(negedge pclk);
      chk("irq_clr", 32'h0, 32'(irq));
      chk_reg("int_clr", `PRS_OFF_INT_STAT, 32'h7, 32'h0);
      // Single-cycle overload pulse is stretched
      apb(1'b1, `PRS_OFF_INT_MASK, 32'h2);
      @(posedge pclk);
      ovl_pulse <= 1'b1;
      @(posedge pclk);
      ovl_pulse <= 1'b0;
      n = 0;
      @(negedge pclk);
      while (ovl_stretched === 1'b1) begin
         @(negedge pclk);
         n++;
      end
      chk("ovl_len", 32'h1, 32'(n >= 4 && n <= 5));
      chk("irq_ovl", 32'h1, 32'(irq));
      chk_reg("int_ovl", `PRS_OFF_INT_STAT, 32'h7, 32'h2);
      // Unmapped address is refused
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped_err", 32'h1, 32'(err));
      chk("unmapped_data", 32'h0, rd);
      // Reset again in mid-search; first search must not switch relays
      tune(3999);
      repeat (20) @(negedge pclk);
      @(posedge pclk);
      presetn <= 1'b0;
      @(negedge pclk);
      chk("range_rst", 32'h1, 32'(range_sel));
      chk("irq_rst", 32'h0, 32'(irq));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(negedge pclk);
      chk("relay_reboot", 32'h0, 32'(relay_drive));
      wait_idle();
      chk_outs(15);
      end_sim();
   end
endmodule : tb_top
